// file: logic/i2c_seq_cfg.svh
// constants of the i2c master sequencer: offsets, fields, resets, timing
`ifndef I2C_SEQ_CFG_SVH
`define I2C_SEQ_CFG_SVH

// ==========================================================
// register byte offsets
`define OFS_RELOAD     8'h00
`define OFS_BUFFER     8'h04
`define OFS_CTRL2      8'h08
`define OFS_STATUS     8'h0c
`define OFS_FLAGS      8'h10

// ==========================================================
// second control register fields
`define B_BEGIN        0
`define B_RBEGIN       1
`define B_RX           3
`define B_ACKVAL       5
`define B_ACKRES       6

// port status register fields
`define B_FULL         0
`define B_STARTSEEN    3

// event flag register fields (write one to clear)
`define B_WRITE_COLLISION_FLAG         0
`define B_OVF          1
`define B_PIF          2
`define B_BCOL         3

// ==========================================================
// reset values and bus answers
`define RELOAD_RST     7'h18
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// bit counter marks
`define LAST_BIT       4'h7
`define ACK_BIT        4'h8

// ==========================================================
// timing: counter steps once per aclk, i.e. twice per instruction cycle
`define CLK_NS         40
`define TCY_NS         (2 * `CLK_NS)
`define WRITE_COLLISION_FLAG_WIN_TCY   2
`define WRITE_COLLISION_FLAG_WIN_CYC   ((`WRITE_COLLISION_FLAG_WIN_TCY * `TCY_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: logic/i2c_seq_pkg.sv
// types of the i2c master sequencer
`default_nettype none
package i2c_seq_pkg;

   // ==========================================================
   // sequencer states
   typedef enum logic [3:0]
   {
      ST_IDLE,
      ST_SEN_WAIT,
      ST_SEN_HOLD,
      ST_RS_LOW,
      ST_RS_SDA,
      ST_RS_SCLH,
      ST_RS_HIGH,
      ST_RS_SDAL,
      ST_BIT_LOW,
      ST_BIT_REL,
      ST_BIT_HIGH
   } state_t;

endpackage : i2c_seq_pkg

`default_nettype wire

// file: logic/i2c_master_sequencer.sv
// i2c master sequencer with axi4-lite register slave
// Operation
// - released scl: counter waits high, then reloads
// - one scl period equals two rollovers
// - start: both high, reload, timeout drives sda
// - after start edge: reload, clear request, hold
// - start with low lines: collision, abort, idle
// - buffer write during start or receive: collision
// - low control bits ignored during start sequences
// - repeated start: scl low, load, release sda
// - repeated start: release scl, high, sda low
// - start seen flag early, interrupt after timeout
// - repeated start ignored while another event runs
// - repeated start collision on sda low or scl
// - buffer write sets full, starts bit clocking
// - eighth fall clears full, ninth samples ack
// - after ninth clock: interrupt, scl held low
// - write while shifting: collision, early rewrite kept
// - receive request ignored unless port idle
// - receive: clock eight bits, load buffer, hold
// - buffer read in receive clears full flag
// - byte arriving with full set flags overflow
// - each instance owns its reload value
// - counter steps each aclk, stops at zero
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`include "i2c_seq_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module i2c_master_sequencer
   import i2c_seq_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe_n,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n
);

   // ==========================================================
   // declarations
   logic        scl_m_r;
   logic        scl_s_r;
   logic        sda_m_r;
   logic        sda_s_r;
   logic        sda_d_r;
   state_t      state_r;
   logic [6:0]  reload_r;
   logic [6:0]  baud_cnt_r;
   logic [3:0]  bit_cnt_r;
   logic [2:0]  age_r;
   logic [7:0]  buf_r;
   logic [7:0]  shift_r;
   logic        rx_mode_r;
   logic        begin_req_r;
   logic        rbegin_req_r;
   logic        rx_req_r;
   logic        ack_val_r;
   logic        ack_result_r;
   logic        buf_full_r;
   logic        start_seen_r;
   logic        wr_coll_r;
   logic        rx_ovf_r;
   logic        port_irq_r;
   logic        bus_coll_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic        wstrb0_r;

   // ==========================================================
   // address decode shared by read and write paths
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == `OFS_RELOAD) || (a == `OFS_BUFFER) ||
                   (a == `OFS_CTRL2) || (a == `OFS_STATUS) ||
                   (a == `OFS_FLAGS);
   endfunction : addr_known

   // write and read strobes
   wire wr_go     = aw_got_r & w_got_r & ~bvalid;
   wire wr_ok     = wr_go & wstrb0_r & addr_known(awaddr_r);
   wire wr_reload = wr_ok & (awaddr_r == `OFS_RELOAD);
   wire wr_buf    = wr_ok & (awaddr_r == `OFS_BUFFER);
   wire wr_ctrl   = wr_ok & (awaddr_r == `OFS_CTRL2);
   wire wr_stat   = wr_ok & (awaddr_r == `OFS_STATUS);
   wire wr_flags  = wr_ok & (awaddr_r == `OFS_FLAGS);
   wire rd_go     = arvalid & arready;
   wire rd_buf    = rd_go & (araddr == `OFS_BUFFER);

   // sequencer conditions
   wire idle       = (state_r == ST_IDLE);
   wire tmo        = (baud_cnt_r == 7'h01);
   wire start_busy = (state_r == ST_SEN_WAIT) || (state_r == ST_SEN_HOLD) ||
                     (state_r == ST_RS_LOW) || (state_r == ST_RS_SDA) ||
                     (state_r == ST_RS_SCLH) || (state_r == ST_RS_HIGH) ||
                     (state_r == ST_RS_SDAL);
   wire bit_state  = (state_r == ST_BIT_LOW) || (state_r == ST_BIT_REL) ||
                     (state_r == ST_BIT_HIGH);
   wire tx_window  = (state_r == ST_BIT_LOW) && !rx_mode_r &&
                     (bit_cnt_r == 4'h0) && (age_r < 3'(`WRITE_COLLISION_FLAG_WIN_CYC));
   wire start_edge = sda_d_r & ~sda_s_r & scl_s_r;
   wire [7:0] rx_byte = {shift_r[6:0], sda_s_r};

   // collisions seen on the lines during start sequences
   wire coll_now =
      ((state_r == ST_SEN_WAIT) && !scl_s_r) ||
      ((state_r == ST_SEN_WAIT) && tmo && !sda_s_r) ||
      ((state_r == ST_RS_SDA) && tmo && !sda_s_r) ||
      ((state_r == ST_RS_SCLH) && scl_s_r && !sda_s_r) ||
      ((state_r == ST_RS_HIGH) && !scl_s_r);

   // read data selection
   wire [31:0] ctrl_word = {25'h0, ack_result_r, ack_val_r, 1'b0, rx_req_r,
                            1'b0, rbegin_req_r, begin_req_r};
   wire [31:0] stat_word = {28'h0, start_seen_r, 2'h0, buf_full_r};
   wire [31:0] flag_word = {28'h0, bus_coll_r, port_irq_r, rx_ovf_r,
                            wr_coll_r};
   wire [31:0] rd_word =
      (araddr == `OFS_RELOAD) ? {25'h0, reload_r} :
      (araddr == `OFS_BUFFER) ? {24'h0, buf_r} :
      (araddr == `OFS_CTRL2)  ? ctrl_word :
      (araddr == `OFS_STATUS) ? stat_word :
      (araddr == `OFS_FLAGS)  ? flag_word : 32'h0;

   // ==========================================================
   // line synchronisers
   always_ff @(posedge aclk)
   begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
   end

   // ==========================================================
   // axi4-lite write and read channels
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready  <= 1'b1;
         wready   <= 1'b1;
         bvalid   <= 1'b0;
         bresp    <= `RESP_OKAY;
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h0;
         wstrb0_r <= 1'b0;
         arready  <= 1'b1;
         rvalid   <= 1'b0;
         rdata    <= 32'h0;
         rresp    <= `RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= awaddr;
            awready  <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_got_r  <= 1'b1;
            wdata_r  <= wdata;
            wstrb0_r <= wstrb[0];
            wready   <= 1'b0;
         end
         if (wr_go)
         begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= addr_known(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
         if (rd_go)
         begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= addr_known(araddr) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready)
         begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // register side effects and bus sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r      <= ST_IDLE;
         reload_r     <= `RELOAD_RST;
         baud_cnt_r   <= 7'h00;
         bit_cnt_r    <= 4'h0;
         age_r        <= 3'h0;
         buf_r        <= 8'h00;
         shift_r      <= 8'h00;
         rx_mode_r    <= 1'b0;
         begin_req_r  <= 1'b0;
         rbegin_req_r <= 1'b0;
         rx_req_r     <= 1'b0;
         ack_val_r    <= 1'b0;
         ack_result_r <= 1'b0;
         buf_full_r   <= 1'b0;
         start_seen_r <= 1'b0;
         wr_coll_r    <= 1'b0;
         rx_ovf_r     <= 1'b0;
         port_irq_r   <= 1'b0;
         bus_coll_r   <= 1'b0;
         scl_oe_n     <= 1'b1;
         sda_oe_n     <= 1'b1;
         scl_out      <= 1'b0;
         sda_out      <= 1'b0;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         // counter runs down and parks at zero
         if (baud_cnt_r != 7'h00)
            baud_cnt_r <= baud_cnt_r - 7'h01;
         if (age_r != 3'h7)
            age_r <= age_r + 3'h1;
         if (wr_reload)
            reload_r <= wdata_r[6:0];
         // clears first, so hardware sets below win
         if (wr_flags)
         begin
            wr_coll_r  <= wr_coll_r & ~wdata_r[`B_WRITE_COLLISION_FLAG];
            rx_ovf_r   <= rx_ovf_r & ~wdata_r[`B_OVF];
            port_irq_r <= port_irq_r & ~wdata_r[`B_PIF];
            bus_coll_r <= bus_coll_r & ~wdata_r[`B_BCOL];
         end
         if (wr_stat && wdata_r[`B_STARTSEEN])
            start_seen_r <= 1'b0;
         if (rd_buf && rx_mode_r)
            buf_full_r <= 1'b0;
         if (start_edge)
            start_seen_r <= 1'b1;
         if (wr_ctrl)
            ack_val_r <= wdata_r[`B_ACKVAL];
         if (coll_now)
         begin
            bus_coll_r   <= 1'b1;
            begin_req_r  <= 1'b0;
            rbegin_req_r <= 1'b0;
            scl_oe_n     <= 1'b1;
            sda_oe_n     <= 1'b1;
            state_r      <= ST_IDLE;
         end
         else
         begin
            case (state_r)
               ST_IDLE:
               begin
                  // requests taken only while idle
                  if (wr_ctrl && wdata_r[`B_BEGIN])
                  begin
                     if (scl_s_r && sda_s_r)
                     begin
                        begin_req_r <= 1'b1;
                        baud_cnt_r  <= reload_r;
                        state_r     <= ST_SEN_WAIT;
                     end
                     else
                        bus_coll_r <= 1'b1;
                  end
                  else if (wr_ctrl && wdata_r[`B_RBEGIN])
                  begin
                     rbegin_req_r <= 1'b1;
                     scl_oe_n     <= 1'b0;
                     state_r      <= ST_RS_LOW;
                  end
                  else if (wr_ctrl && wdata_r[`B_RX])
                  begin
                     rx_req_r   <= 1'b1;
                     rx_mode_r  <= 1'b1;
                     bit_cnt_r  <= 4'h0;
                     scl_oe_n   <= 1'b0;
                     sda_oe_n   <= 1'b1;
                     baud_cnt_r <= reload_r;
                     state_r    <= ST_BIT_LOW;
                  end
                  else if (wr_buf)
                  begin
                     buf_r      <= wdata_r[7:0];
                     shift_r    <= wdata_r[7:0];
                     buf_full_r <= 1'b1;
                     rx_mode_r  <= 1'b0;
                     age_r      <= 3'h0;
                     bit_cnt_r  <= 4'h0;
                     scl_oe_n   <= 1'b0;
                     sda_oe_n   <= wdata_r[7];
                     baud_cnt_r <= reload_r;
                     state_r    <= ST_BIT_LOW;
                  end
               end
               ST_SEN_WAIT:
                  if (tmo)
                  begin
                     sda_oe_n     <= 1'b0;
                     start_seen_r <= 1'b1;
                     baud_cnt_r   <= reload_r;
                     state_r      <= ST_SEN_HOLD;
                  end
               ST_SEN_HOLD:
                  if (tmo)
                  begin
                     begin_req_r <= 1'b0;
                     scl_oe_n    <= 1'b0;
                     port_irq_r  <= 1'b1;
                     state_r     <= ST_IDLE;
                  end
               ST_RS_LOW:
                  if (!scl_s_r)
                  begin
                     baud_cnt_r <= {1'b0, reload_r[5:0]};
                     sda_oe_n   <= 1'b1;
                     state_r    <= ST_RS_SDA;
                  end
               ST_RS_SDA:
                  if (tmo)
                  begin
                     scl_oe_n <= 1'b1;
                     state_r  <= ST_RS_SCLH;
                  end
               ST_RS_SCLH:
                  if (scl_s_r)
                  begin
                     baud_cnt_r <= reload_r;
                     state_r    <= ST_RS_HIGH;
                  end
               ST_RS_HIGH:
                  if (tmo)
                  begin
                     sda_oe_n   <= 1'b0;
                     baud_cnt_r <= reload_r;
                     state_r    <= ST_RS_SDAL;
                  end
               ST_RS_SDAL:
                  if (tmo)
                  begin
                     rbegin_req_r <= 1'b0;
                     port_irq_r   <= 1'b1;
                     state_r      <= ST_IDLE;
                  end
               ST_BIT_LOW:
                  if (tmo)
                  begin
                     scl_oe_n <= 1'b1;
                     state_r  <= ST_BIT_REL;
                  end
               ST_BIT_REL:
                  // counter parked until the line is really high
                  if (scl_s_r)
                  begin
                     baud_cnt_r <= reload_r;
                     state_r    <= ST_BIT_HIGH;
                  end
               ST_BIT_HIGH:
                  if (tmo)
                  begin
                     scl_oe_n  <= 1'b0;
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                     if (rx_mode_r)
                     begin
                        shift_r <= rx_byte;
                        if (bit_cnt_r == `LAST_BIT)
                        begin
                           rx_req_r   <= 1'b0;
                           buf_r      <= rx_byte;
                           buf_full_r <= 1'b1;
                           port_irq_r <= 1'b1;
                           if (buf_full_r)
                              rx_ovf_r <= 1'b1;
                           state_r    <= ST_IDLE;
                        end
                        else
                        begin
                           baud_cnt_r <= reload_r;
                           state_r    <= ST_BIT_LOW;
                        end
                     end
                     else if (bit_cnt_r == `ACK_BIT)
                     begin
                        ack_result_r <= sda_s_r;
                        port_irq_r   <= 1'b1;
                        state_r      <= ST_IDLE;
                     end
                     else
                     begin
                        if (bit_cnt_r == `LAST_BIT)
                        begin
                           buf_full_r <= 1'b0;
                           sda_oe_n   <= 1'b1;
                        end
                        else
                           sda_oe_n <= shift_r[6];
                        shift_r    <= {shift_r[6:0], 1'b0};
                        baud_cnt_r <= reload_r;
                        state_r    <= ST_BIT_LOW;
                     end
                  end
               default:
                  state_r <= ST_IDLE;
            endcase
         end
         // buffer writes while busy collide; an early rewrite still lands
         if (wr_buf && !idle)
         begin
            wr_coll_r <= 1'b1;
            if (tx_window)
            begin
               buf_r    <= wdata_r[7:0];
               shift_r  <= wdata_r[7:0];
               sda_oe_n <= wdata_r[7];
            end
         end
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_start_drive;
      state_r == ST_SEN_WAIT && tmo && scl_s_r && sda_s_r;
   endsequence
   sequence s_rs_fall;
      state_r == ST_RS_HIGH && tmo && scl_s_r;
   endsequence

   property p_start_fall;
      s_start_drive |=> !sda_oe_n && start_seen_r && state_r == ST_SEN_HOLD;
   endproperty
   a_start_fall: assert property (p_start_fall)
      else $error("start edge not driven");

   property p_start_done;
      state_r == ST_SEN_HOLD && tmo |=>
         !begin_req_r && !sda_oe_n && baud_cnt_r == 7'h00;
   endproperty
   a_start_done: assert property (p_start_done)
      else $error("start completion wrong");

   property p_start_coll;
      state_r == ST_SEN_WAIT && !scl_s_r |=> bus_coll_r && idle && sda_oe_n;
   endproperty
   a_start_coll: assert property (p_start_coll)
      else $error("start collision not taken");

   property p_write_collision_flag_start;
      wr_buf && (start_busy || rx_mode_r && bit_state) |=>
         wr_coll_r && $stable(buf_r);
   endproperty
   a_write_collision_flag_start: assert property (p_write_collision_flag_start)
      else $error("busy buffer write not refused");

   property p_pause;
      state_r == ST_BIT_REL && !scl_s_r |=>
         state_r == ST_BIT_REL && baud_cnt_r == 7'h00;
   endproperty
   a_pause: assert property (p_pause)
      else $error("counter ran while scl held low");

   property p_tx_go;
      wr_buf && idle |=> buf_full_r && state_r == ST_BIT_LOW && !scl_oe_n
         && baud_cnt_r == $past(reload_r);
   endproperty
   a_tx_go: assert property (p_tx_go)
      else $error("transmit did not start");

   property p_ack;
      state_r == ST_BIT_HIGH && tmo && !rx_mode_r && bit_cnt_r == `ACK_BIT
         |=> port_irq_r && ack_result_r == $past(sda_s_r) && !scl_oe_n
         ##1 idle && !scl_oe_n;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack handling wrong");

   property p_ovf;
      state_r == ST_BIT_HIGH && tmo && rx_mode_r &&
         bit_cnt_r == `LAST_BIT && buf_full_r |=> rx_ovf_r && buf_full_r;
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow not flagged");

   property p_rs_ignore;
      wr_ctrl && wdata_r[`B_RBEGIN] && bit_state |=> !rbegin_req_r;
   endproperty
   a_rs_ignore: assert property (p_rs_ignore)
      else $error("repeated start taken while busy");

   property p_rs_fall;
      s_rs_fall |=> !sda_oe_n && scl_oe_n && state_r == ST_RS_SDAL;
   endproperty
   a_rs_fall: assert property (p_rs_fall)
      else $error("repeated start edge wrong");

   property p_dec;
      baud_cnt_r > 7'h01 |=> baud_cnt_r == $past(baud_cnt_r) - 7'h01;
   endproperty
   a_dec: assert property (p_dec)
      else $error("counter did not step down");

endmodule : i2c_master_sequencer

`default_nettype wire

// file: logic/README_unused.sv
// no logic here: the whole sequencer lives in one design file

// file: testbench/i2c_slave_model.sv
// far-side model: i2c slave that takes, sends, acks and stretches
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       clr,
   input  wire logic       rdm,
   input  wire logic       nack,
   input  wire logic       slow,
   input  wire logic [7:0] tx,
   output logic            scl_oe_n = 1'b1,
   output logic            sda_oe_n = 1'b1,
   output logic [7:0]      rx = 8'h00
);
   logic [3:0] n = 4'h0;
   // ==========================================================
   // new byte: first bit to send shown at once
   always @(posedge clr)
   begin
      n = 4'h0;
      sda_oe_n = !(rdm && !tx[7]);
   end
   // take the master's bits while scl is high
   always @(posedge scl)
      if (n < 4'h8) rx = {rx[6:0], sda};
   // after a fall: hold time, next bit or ack, then maybe stretch
   always @(negedge scl)
   begin
      n = n + 4'h1;
      #60;
      if (n < 4'h8) sda_oe_n = !(rdm && !tx[7 - n]);
      else sda_oe_n = !(n == 4'h8 && !rdm && !nack);
      if (slow)
      begin
         scl_oe_n = 1'b0;
         #1000 scl_oe_n = 1'b1;
      end
   end
endmodule : i2c_slave_model
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench of the i2c master sequencer
`include "i2c_seq_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int T = 4;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, clr = 1'b0;
   logic rdm = 1'b0, nack = 1'b0, slow = 1'b0, scl, sda;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx = 8'h00, b, rx;
   logic [31:0] wdata = 32'h0, rdata, m;
   logic [1:0]  bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid;
   logic scl_oe_n, sda_oe_n, p_scl_oe_n, p_sda_oe_n;
   logic scl_out, sda_out;
   logic [33:0] exp_q[$];
   logic [31:0] msk_q[$];
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   // ==========================================================
   // open-drain lines with pull-ups
   assign scl = scl_oe_n & p_scl_oe_n;
   assign sda = sda_oe_n & p_sda_oe_n;
   i2c_master_sequencer DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out,
      .sda_oe_n);
   i2c_slave_model far (.scl, .sda, .clr, .rdm, .nack, .slow, .tx,
      .scl_oe_n(p_scl_oe_n), .sda_oe_n(p_sda_oe_n), .rx);
   initial forever #20 aclk = ~aclk;
   // hang guard
   always @(posedge aclk)
      if (++cyc == 5000)
      begin
         n_mismatch++;
         end_sim();
      end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [33:0] got, input logic [33:0] e);
      samples_checked++;
      if (got !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, e);
      end
   endtask : chk
   // ==========================================================
   // register bus master tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e,
                     input logic [31:0] mk);
      exp_q.push_back(e);
      msk_q.push_back(mk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
   endtask : rd
   // compare each read answer with the oldest note
   always @(posedge aclk)
      if (rvalid && rready)
      begin
         m = msk_q.pop_front();
         chk({rresp, rdata & m}, exp_q.pop_front());
      end
   // ==========================================================
   initial
   begin
      void'($urandom(65));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`OFS_RELOAD, {27'h0, `RELOAD_RST}, 32'hff);
      rd(8'h20, {`RESP_SLVERR, 32'h0}, 32'hffffffff);
      wr(`OFS_RELOAD, T);
      rd(`OFS_RELOAD, {27'h0, 7'(T)}, 32'h7f);
      wr(`OFS_CTRL2, 32'h1);
      wr(`OFS_BUFFER, 32'ha5);
      repeat (40) @(posedge aclk);
      rd(`OFS_FLAGS, 34'h5, 32'hf);
      rd(`OFS_STATUS, 34'h8, 32'h9);
      rd(`OFS_CTRL2, 34'h0, 32'h1);
      wr(`OFS_FLAGS, 32'hf);
      wr(`OFS_STATUS, 32'h8);
      for (int k = 0; k < 2; k++)
      begin
         b = 8'($urandom);
         nack <= k[0];
         slow <= k[0];
         clr <= 1'b1;
         wr(`OFS_BUFFER, {24'h0, b});
         clr <= 1'b0;
         // second pass rewrites at once, inside the early window
         if (k == 0) repeat (8) @(posedge aclk);
         wr(`OFS_BUFFER, {24'h0, ~b});
         repeat (400) @(posedge aclk);
         chk({26'h0, rx}, {26'h0, k[0] ? ~b : b});
         rd(`OFS_CTRL2, {27'h0, k[0], 6'h0}, 32'h40);
         rd(`OFS_FLAGS, 34'h5, 32'hf);
         rd(`OFS_STATUS, 34'h0, 32'h1);
         wr(`OFS_FLAGS, 32'hf);
      end
      rdm <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         tx <= 8'($urandom);
         @(posedge aclk);
         clr <= 1'b1;
         wr(`OFS_CTRL2, 32'h8);
         clr <= 1'b0;
         wr(`OFS_CTRL2, 32'h2);
         wr(`OFS_BUFFER, 32'h0);
         repeat (400) @(posedge aclk);
         rd(`OFS_CTRL2, 34'h0, 32'ha);
         rd(`OFS_FLAGS, {31'h0, 1'b1, k[0], 1'b1}, 32'hf);
         wr(`OFS_FLAGS, 32'hf);
      end
      rd(`OFS_STATUS, 34'h1, 32'h1);
      rd(`OFS_BUFFER, {26'h0, tx}, 32'hff);
      rd(`OFS_STATUS, 34'h0, 32'h1);
      rdm <= 1'b0;
      wr(`OFS_CTRL2, 32'h2);
      repeat (60) @(posedge aclk);
      rd(`OFS_FLAGS, 34'h4, 32'hf);
      rd(`OFS_STATUS, 34'h8, 32'h8);
      chk({30'h0, scl_out, sda_out, scl, sda}, 34'h2);
      wr(`OFS_FLAGS, 32'hf);
      wr(`OFS_CTRL2, 32'h1);
      repeat (20) @(posedge aclk);
      rd(`OFS_FLAGS, 34'h8, 32'hc);
      rd(`OFS_CTRL2, 34'h0, 32'h1);
      end_sim();
   end
endmodule : tb
`default_nettype wire
